/* File: shared/dpmx_consts.svh */
// Constants for the DSP memory pin multiplexer: offsets, field positions, reset values.
`ifndef DPMX_CONSTS_SVH
`define DPMX_CONSTS_SVH
`define DPMX_OFS_B_DATA 16'h0000
`define DPMX_OFS_B_DIR 16'h0001
`define DPMX_OFS_B_OD 16'h0002
`define DPMX_OFS_B_PIN 16'h0003
`define DPMX_OFS_C_DATA 16'h0004
`define DPMX_OFS_C_DIR 16'h0005
`define DPMX_OFS_C_OD 16'h0006
`define DPMX_OFS_C_PIN 16'h0007
`define DPMX_OFS_D_DATA 16'h0008
`define DPMX_OFS_D_DIR 16'h0009
`define DPMX_OFS_D_PIN 16'h000A
`define DPMX_OFS_PAGE 16'h000B
`define DPMX_OFS_STATUS 16'h000C
`define DPMX_RST_BYTE 8'h00
`define DPMX_BIT_JTAG_TMS 0
`define DPMX_BIT_JTAG_TCK 1
`define DPMX_BIT_A16 2
`define DPMX_BIT_RDYBSY 3
`define DPMX_BIT_ERR 4
`define DPMX_BIT_JTAG_TDI 5
`define DPMX_BIT_JTAG_TDO 6
`define DPMX_BIT_A17 7
`endif

/* File: shared/dpmx_pkg.sv */
// Types shared by the DSP memory pin multiplexer.
package dpmx_pkg;
    typedef enum logic [1:0] {DPMX_FN_IO, DPMX_FN_MCELL, DPMX_FN_INPUT} dpmx_fn_e;
    typedef struct packed {
        logic [15:0] addr;
        logic wr_n;
        logic rd_n;
        logic bms_n;
    } dpmx_bus_s;
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] od;
    } dpmx_port_s;
    typedef struct packed {
        logic jtag_en;
        logic xjtag_en;
        logic rdybsy_en;
        logic full_mem;
    } dpmx_alt_s;
endpackage

/* File: hw/dpmx_pin.sv */
// One multiplexed port pin: function select, drive mode and two-flop input sync.
`timescale 1ns/100ps
module dpmx_pin (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire dpmx_pkg::dpmx_fn_e fn_i,
    input wire logic io_data_i,
    input wire logic io_dir_i,
    input wire logic od_i,
    input wire logic mcell_i,
    input wire logic alt_en_i,
    input wire logic alt_val_i,
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    output logic sync_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic o;
        logic oe;
    } dpmx_pin_s;
    dpmx_pin_s q;
    dpmx_pin_s next_q;
    logic lvl;
    logic en;
    logic od_eff;
    always_comb
    begin
        next_q = q;
        next_q.s1 = pad_i;
        next_q.s2 = q.s1;
        lvl = 1'b0;
        en = 1'b0;
        od_eff = od_i & ~alt_en_i;
        if (alt_en_i)
        begin
            lvl = alt_val_i;
            en = 1'b1;
        end
        else
        begin
            case (fn_i)
                dpmx_pkg::DPMX_FN_IO:
                begin
                    lvl = io_data_i;
                    en = io_dir_i;
                end
                dpmx_pkg::DPMX_FN_MCELL:
                begin
                    lvl = mcell_i;
                    en = 1'b1;
                end
                default:
                begin
                    lvl = 1'b0;
                    en = 1'b0;
                end
            endcase
        end
        next_q.o = od_eff ? 1'b0 : lvl;
        next_q.oe = en & ~(od_eff & lvl);
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= next_q;
    end
    assign pad_o = q.o;
    assign pad_oe_o = q.oe;
    assign sync_o = q.s2;
endmodule

/* File: hw/dpmx_top.sv */
// DSP memory pin multiplexer top: DSP strobe interface, port registers and pin muxing.
`timescale 1ns/100ps
`include "dpmx_consts.svh"
module dpmx_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] dsp_address_in_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic byte_mem_select_n_i,
    input wire logic [7:0] upper_data_port_i,
    output logic [7:0] upper_data_port_o,
    output logic upper_data_port_oe_o,
    input wire dpmx_pkg::dpmx_fn_e [7:0] port_b_fn_i,
    input wire dpmx_pkg::dpmx_fn_e [7:0] port_c_fn_i,
    input wire dpmx_pkg::dpmx_alt_s alt_cfg_i,
    input wire logic [7:0] mcell_b_i,
    input wire logic [7:0] mcell_c_i,
    input wire logic isp_status_i,
    input wire logic isp_error_i,
    input wire logic isp_tdo_i,
    input wire logic flash_busy_i,
    input wire logic [7:0] port_b_i,
    output logic [7:0] port_b_o,
    output logic [7:0] port_b_oe_o,
    input wire logic [7:0] port_c_i,
    output logic [7:0] port_c_o,
    output logic [7:0] port_c_oe_o,
    input wire logic [2:0] port_d_i,
    output logic [2:0] port_d_o,
    output logic [2:0] port_d_oe_o,
    output logic [7:0] pld_in_b_o,
    output logic [7:0] pld_in_c_o,
    output logic [2:0] pld_in_d_o,
    output logic [17:0] decode_addr_o,
    output logic byte_space_select_o,
    output logic [7:0] page_o
);
    // ******************************************************
    // State
    // ******************************************************
    typedef struct packed {
        logic [2:0] s_wr;
        logic [2:0] s_rd;
        logic [1:0] s_bms;
        logic [15:0] a1;
        logic [15:0] a2;
        logic [7:0] d1;
        logic [7:0] d2;
        dpmx_pkg::dpmx_port_s pb;
        dpmx_pkg::dpmx_port_s pc;
        logic [2:0] pd_data;
        logic [2:0] pd_dir;
        logic [7:0] page;
        logic [7:0] rdata;
        logic rd_oe;
        logic [17:0] dec;
        logic byte_space_select;
        dpmx_pkg::dpmx_alt_s alt;
    } dpmx_top_s;
    dpmx_top_s q;
    dpmx_top_s next_q;
    logic [7:0] b_sync;
    logic [7:0] c_sync;
    logic [2:0] d_sync;
    logic [7:0] c_alt_en;
    logic [7:0] c_alt_val;
    logic [7:0] b_od;
    logic wr_fall;
    // ******************************************************
    // Alternate functions on Port C
    // ******************************************************
    always_comb
    begin
        c_alt_en = 8'h00;
        c_alt_val = 8'h00;
        c_alt_en[`DPMX_BIT_JTAG_TDO] = q.alt.jtag_en;
        c_alt_val[`DPMX_BIT_JTAG_TDO] = isp_tdo_i;
        if (q.alt.rdybsy_en)
        begin
            c_alt_en[`DPMX_BIT_RDYBSY] = 1'b1;
            c_alt_val[`DPMX_BIT_RDYBSY] = ~flash_busy_i;
        end
        else if (q.alt.xjtag_en)
        begin
            c_alt_en[`DPMX_BIT_RDYBSY] = 1'b1;
            c_alt_val[`DPMX_BIT_RDYBSY] = isp_status_i;
        end
        c_alt_en[`DPMX_BIT_ERR] = q.alt.xjtag_en;
        c_alt_val[`DPMX_BIT_ERR] = isp_error_i;
        b_od = {4'h0, q.pb.od[3:0]};
    end
    // ******************************************************
    // Pins
    // ******************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_bc
            dpmx_pin u_b (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .fn_i(port_b_fn_i[gi]),
                .io_data_i(q.pb.data[gi]),
                .io_dir_i(q.pb.dir[gi]),
                .od_i(b_od[gi]),
                .mcell_i(mcell_b_i[gi]),
                .alt_en_i(1'b0),
                .alt_val_i(1'b0),
                .pad_i(port_b_i[gi]),
                .pad_o(port_b_o[gi]),
                .pad_oe_o(port_b_oe_o[gi]),
                .sync_o(b_sync[gi])
            );
            dpmx_pin u_c (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .fn_i(port_c_fn_i[gi]),
                .io_data_i(q.pc.data[gi]),
                .io_dir_i(q.pc.dir[gi]),
                .od_i(q.pc.od[gi]),
                .mcell_i(mcell_c_i[gi]),
                .alt_en_i(c_alt_en[gi]),
                .alt_val_i(c_alt_val[gi]),
                .pad_i(port_c_i[gi]),
                .pad_o(port_c_o[gi]),
                .pad_oe_o(port_c_oe_o[gi]),
                .sync_o(c_sync[gi])
            );
        end
        for (gi = 0; gi < 3; gi++)
        begin : g_d
            dpmx_pin u_d (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .fn_i(dpmx_pkg::DPMX_FN_IO),
                .io_data_i(q.pd_data[gi]),
                .io_dir_i(q.pd_dir[gi]),
                .od_i(1'b0),
                .mcell_i(1'b0),
                .alt_en_i(1'b0),
                .alt_val_i(1'b0),
                .pad_i(port_d_i[gi]),
                .pad_o(port_d_o[gi]),
                .pad_oe_o(port_d_oe_o[gi]),
                .sync_o(d_sync[gi])
            );
        end
    endgenerate
    // ******************************************************
    // DSP bus and registers
    // ******************************************************
    assign wr_fall = ~q.s_wr[1] & q.s_wr[2];
    always_comb
    begin
        next_q = q;
        next_q.s_wr = {q.s_wr[1:0], write_strobe_n_i};
        next_q.s_rd = {q.s_rd[1:0], read_strobe_n_i};
        next_q.s_bms = {q.s_bms[0], byte_mem_select_n_i};
        next_q.a1 = dsp_address_in_i;
        next_q.a2 = q.a1;
        next_q.d1 = upper_data_port_i;
        next_q.d2 = q.d1;
        next_q.byte_space_select = ~q.s_bms[1];
        next_q.dec = {c_sync[`DPMX_BIT_A17] & q.alt.full_mem,
            c_sync[`DPMX_BIT_A16] & q.alt.full_mem,
            q.a2};
        if (wr_fall)
        begin
            case (q.a2)
                `DPMX_OFS_B_DATA: next_q.pb.data = q.d2;
                `DPMX_OFS_B_DIR: next_q.pb.dir = q.d2;
                `DPMX_OFS_B_OD: next_q.pb.od = {4'h0, q.d2[3:0]};
                `DPMX_OFS_C_DATA: next_q.pc.data = q.d2;
                `DPMX_OFS_C_DIR: next_q.pc.dir = q.d2;
                `DPMX_OFS_C_OD: next_q.pc.od = q.d2;
                `DPMX_OFS_D_DATA: next_q.pd_data = q.d2[2:0];
                `DPMX_OFS_D_DIR: next_q.pd_dir = q.d2[2:0];
                `DPMX_OFS_PAGE: next_q.page = q.d2;
                default: next_q.page = q.page;
            endcase
        end
        case (q.a2)
            `DPMX_OFS_B_DATA: next_q.rdata = q.pb.data;
            `DPMX_OFS_B_DIR: next_q.rdata = q.pb.dir;
            `DPMX_OFS_B_OD: next_q.rdata = q.pb.od;
            `DPMX_OFS_B_PIN: next_q.rdata = b_sync;
            `DPMX_OFS_C_DATA: next_q.rdata = q.pc.data;
            `DPMX_OFS_C_DIR: next_q.rdata = q.pc.dir;
            `DPMX_OFS_C_OD: next_q.rdata = q.pc.od;
            `DPMX_OFS_C_PIN: next_q.rdata = c_sync;
            `DPMX_OFS_D_DATA: next_q.rdata = {5'h00, q.pd_data};
            `DPMX_OFS_D_DIR: next_q.rdata = {5'h00, q.pd_dir};
            `DPMX_OFS_D_PIN: next_q.rdata = {5'h00, d_sync};
            `DPMX_OFS_PAGE: next_q.rdata = q.page;
            `DPMX_OFS_STATUS: next_q.rdata = {7'h00, ~flash_busy_i};
            default: next_q.rdata = `DPMX_RST_BYTE;
        endcase
        next_q.rd_oe = ~q.s_rd[1];
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.s_wr <= 3'h7;
            q.s_rd <= 3'h7;
            q.s_bms <= 2'h3;
        end
        else
        begin
            q <= next_q;
            q.alt <= alt_cfg_i;
        end
    end
    assign upper_data_port_o = q.rdata;
    assign upper_data_port_oe_o = q.rd_oe;
    assign pld_in_b_o = b_sync;
    assign pld_in_c_o = c_sync;
    assign pld_in_d_o = d_sync;
    assign decode_addr_o = q.dec;
    assign byte_space_select_o = q.byte_space_select;
    assign page_o = q.page;
    // ******************************************************
    // Bus checks
    // ******************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_read_drive_low: assert property
        (q.s_rd[1] |=> !upper_data_port_oe_o)
        else $error("Data driven without read.");
    a_read_drive_on: assert property
        (!q.s_rd[1] |=> upper_data_port_oe_o)
        else $error("Data not driven during read.");
    a_write_page_upd: assert property
        (wr_fall && q.a2 == `DPMX_OFS_PAGE |=> page_o == $past(q.d2))
        else $error("Page not written.");
    a_no_write_idle: assert property
        (!wr_fall |=> $stable(page_o))
        else $error("Page changed without write.");
    a_unmapped_write: assert property
        (wr_fall && q.a2 > `DPMX_OFS_STATUS |=> $stable(page_o) && $stable(q.pb) && $stable(q.pc))
        else $error("Unmapped write changed a register.");
    a_unmapped_read: assert property
        (q.a2 > `DPMX_OFS_STATUS |=> upper_data_port_o == 8'h00)
        else $error("Unmapped read not zero.");
    a_page_read: assert property
        (q.a2 == `DPMX_OFS_PAGE |=> upper_data_port_o == $past(q.page))
        else $error("Page read wrong.");
    a_status_read: assert property
        (q.a2 == `DPMX_OFS_STATUS |=> upper_data_port_o == {7'h00, $past(!flash_busy_i)})
        else $error("Status read wrong.");
    a_reset_page: assert property
        ($past(rst_i) |-> page_o == `DPMX_RST_BYTE)
        else $error("Page not reset.");
    a_bms_follow: assert property
        (byte_mem_select_n_i ##2 1 |=> !byte_space_select_o)
        else $error("Byte select wrong.");
    a_bms_low: assert property
        (!byte_mem_select_n_i ##2 1 |=> byte_space_select_o)
        else $error("Byte select missed.");
    a_full_mem_off: assert property
        (!q.alt.full_mem |=> decode_addr_o[17:16] == 2'b00)
        else $error("High address bits without full memory mode.");
    // ******************************************************
    // Pin checks
    // ******************************************************
    a_rdybsy_pin: assert property
        (q.alt.rdybsy_en && flash_busy_i ##1 q.alt.rdybsy_en |-> !port_c_o[`DPMX_BIT_RDYBSY])
        else $error("Ready/busy wrong.");
    a_jtag_tdo_oe: assert property
        (q.alt.jtag_en |=> port_c_oe_o[`DPMX_BIT_JTAG_TDO])
        else $error("TDO not driven.");
    a_tdo_level: assert property
        (q.alt.jtag_en |=> port_c_o[`DPMX_BIT_JTAG_TDO] == $past(isp_tdo_i))
        else $error("TDO level wrong.");
    a_tms_input: assert property
        (q.alt.jtag_en && port_c_fn_i[0] == dpmx_pkg::DPMX_FN_IO && !q.pc.dir[0] |=> !port_c_oe_o[0])
        else $error("Mode select pin driven.");
    a_err_oe: assert property
        (q.alt.xjtag_en |=> port_c_oe_o[`DPMX_BIT_ERR])
        else $error("Error pin not driven.");
    a_err_level: assert property
        (q.alt.xjtag_en |=> port_c_o[`DPMX_BIT_ERR] == $past(isp_error_i))
        else $error("Error pin level wrong.");
    a_status_pin: assert property
        (q.alt.xjtag_en && !q.alt.rdybsy_en |=> port_c_oe_o[3] && port_c_o[3] == $past(isp_status_i))
        else $error("Status pin wrong.");
    a_od_b_high: assert property
        (b_od[0] |=> !port_b_o[0])
        else $error("Open drain drives high.");
    a_od_b_upper: assert property
        (wr_fall && q.a2 == `DPMX_OFS_B_OD |=> q.pb.od[7:4] == 4'h0)
        else $error("Upper open drain bits set.");
    a_od_c_low: assert property
        (q.pc.od[0] && !c_alt_en[0] |=> !port_c_o[0])
        else $error("Port C open drain drives high.");
    a_mcell_b: assert property
        (port_b_fn_i[1] == dpmx_pkg::DPMX_FN_MCELL && !b_od[1] |=> port_b_oe_o[1] && port_b_o[1] == $past(mcell_b_i[1]))
        else $error("Macrocell output wrong.");
    a_input_c: assert property
        (port_c_fn_i[1] == dpmx_pkg::DPMX_FN_INPUT && !c_alt_en[1] |=> !port_c_oe_o[1])
        else $error("Input pin driven.");
    a_d_dir_off: assert property
        (q.pd_dir == 3'h0 |=> port_d_oe_o == 3'h0)
        else $error("Port D driven as input.");
    a_d_level: assert property
        (q.pd_dir[0] |=> port_d_oe_o[0] && port_d_o[0] == $past(q.pd_data[0]))
        else $error("Port D level wrong.");
    // ******************************************************
    // Cover
    // ******************************************************
    c_reg_write: cover property (wr_fall);
    c_read_cycle: cover property (upper_data_port_oe_o [*2]);
    c_rdybsy_on: cover property (q.alt.rdybsy_en && port_c_oe_o[3]);
    c_byte_space: cover property (byte_space_select_o);
    c_full_mem: cover property (decode_addr_o[17:16] == 2'b11);
endmodule

/* File: tb/dpmx_dsp_model.sv */
// DSP-side bus model that drives the address, the strobes and the upper data byte.
`timescale 1ns/100ps
module dpmx_dsp_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_oe_i,
    output dpmx_pkg::dpmx_bus_s bus_o,
    output logic [7:0] wdata_o
);
    int extra = 0;

    initial
    begin
        bus_o = {16'h0000, 3'b111};
        wdata_o = 8'h00;
    end

    // Write cycle. The data lines keep the value for four edges after the strobe rises and then show the inverse value.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        bus_o.addr <= a;
        wdata_o <= d;
        bus_o.wr_n <= 1'b0;
        repeat (5 + extra) @(posedge clk_sys_i);
        bus_o.wr_n <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        wdata_o <= ~d;
    endtask

    // Read cycle. The answer is taken at the fourth edge after the strobe falls.
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
        @(posedge clk_sys_i);
        bus_o.addr <= a;
        bus_o.rd_n <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        d = rdata_i;
        oe = rdata_oe_i;
        bus_o.rd_n <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask

    // Byte memory space select.
    task automatic sel(input logic s);
        @(posedge clk_sys_i);
        bus_o.bms_n <= ~s;
    endtask
endmodule

/* File: tb/test_dpmx_top.sv */
// Self-checking bench for the DSP memory pin multiplexer.
`timescale 1ns/100ps
`include "dpmx_consts.svh"
module test_dpmx_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    dpmx_pkg::dpmx_bus_s bus;
    logic [7:0] wdata, rdata_o, b_o, b_oe, c_o, c_oe, mc_c, pld_b, pld_c, page, rd_v;
    logic [7:0] ext_b = 8'hFF;
    logic [7:0] ext_c = 8'hFF;
    logic [7:0] mc_b = 8'h00;
    logic [2:0] d_o, d_oe, pld_d;
    logic [2:0] ext_d = 3'h7;
    logic rdata_oe, bss, rd_oe;
    logic isp_status_out = 1'b0;
    logic isp_error_out = 1'b0;
    logic tdo = 1'b0;
    logic busy = 1'b0;
    logic [17:0] dec;
    dpmx_pkg::dpmx_fn_e [7:0] fn_b, fn_c;
    dpmx_pkg::dpmx_alt_s alt = 4'h0;
    int error_cnt = 0;
    int num_checks = 0;
    // Pad levels: driven value where enabled, otherwise the pulled-up outside level.
    wire [7:0] pad_b = (b_oe & b_o) | (~b_oe & ext_b);
    wire [7:0] pad_c = (c_oe & c_o) | (~c_oe & ext_c);
    wire [2:0] pad_d = (d_oe & d_o) | (~d_oe & ext_d);

    always #5 clk_sys_i = ~clk_sys_i;

    dpmx_top uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .dsp_address_in_i(bus.addr),
        .write_strobe_n_i(bus.wr_n), .read_strobe_n_i(bus.rd_n), .byte_mem_select_n_i(bus.bms_n),
        .upper_data_port_i(wdata), .upper_data_port_o(rdata_o), .upper_data_port_oe_o(rdata_oe),
        .port_b_fn_i(fn_b), .port_c_fn_i(fn_c), .alt_cfg_i(alt), .mcell_b_i(mc_b), .mcell_c_i(mc_c),
        .isp_status_i(isp_status_out), .isp_error_i(isp_error_out), .isp_tdo_i(tdo), .flash_busy_i(busy),
        .port_b_i(pad_b), .port_b_o(b_o), .port_b_oe_o(b_oe), .port_c_i(pad_c), .port_c_o(c_o),
        .port_c_oe_o(c_oe), .port_d_i(pad_d), .port_d_o(d_o), .port_d_oe_o(d_oe),
        .pld_in_b_o(pld_b), .pld_in_c_o(pld_c), .pld_in_d_o(pld_d), .decode_addr_o(dec),
        .byte_space_select_o(bss), .page_o(page)
    );

    dpmx_dsp_model u_dsp (
        .clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .rdata_oe_i(rdata_oe), .bus_o(bus), .wdata_o(wdata)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        u_dsp.rd(a, rd_v, rd_oe);
        chk("read data", exp, rd_v);
        chk("read enable", 1'b1, rd_oe);
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
    endtask

    // Covers the two-flop input sync plus the registered pin stage.
    task automatic settle();
        repeat (8) @(posedge clk_sys_i);
    endtask

    task automatic set_fn(input dpmx_pkg::dpmx_fn_e fb, input dpmx_pkg::dpmx_fn_e fc);
        @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++)
        begin
            fn_b[i] <= fb;
            fn_c[i] <= fc;
        end
    endtask

    task automatic chk_rst();
        logic [15:0] ofs [9] = '{`DPMX_OFS_B_DATA, `DPMX_OFS_B_DIR, `DPMX_OFS_B_OD, `DPMX_OFS_C_DATA,
            `DPMX_OFS_C_DIR, `DPMX_OFS_C_OD, `DPMX_OFS_D_DATA, `DPMX_OFS_D_DIR, `DPMX_OFS_PAGE};
        foreach (ofs[i])
            rchk(ofs[i], `DPMX_RST_BYTE);
        chk("page", `DPMX_RST_BYTE, page);
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        finish_test();
    end

    initial
    begin
        mc_c = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            fn_b[i] = dpmx_pkg::DPMX_FN_IO;
            fn_c[i] = dpmx_pkg::DPMX_FN_IO;
        end
        do_reset();
        chk_rst();
        chk("port oe", 19'h0, {b_oe, c_oe, d_oe});
        u_dsp.wr(`DPMX_OFS_B_DATA, 8'hA5);
        u_dsp.wr(`DPMX_OFS_PAGE, 8'h3C);
        u_dsp.wr(16'h010B, 8'hFF);
        rchk(`DPMX_OFS_B_DATA, 8'hA5);
        rchk(`DPMX_OFS_PAGE, 8'h3C);
        chk("page", 8'h3C, page);
        rchk(16'h000D, 8'h00);
        chk("idle read enable", 1'b0, rdata_oe);
        u_dsp.wr(`DPMX_OFS_B_DIR, 8'hFF);
        u_dsp.wr(`DPMX_OFS_D_DIR, 8'h07);
        u_dsp.wr(`DPMX_OFS_D_DATA, 8'h05);
        settle();
        chk("b out", 16'hA5FF, {b_o, b_oe});
        chk("d out", 6'h2F, {d_o, d_oe});
        rchk(`DPMX_OFS_B_PIN, 8'hA5);
        chk("pld b", 8'hA5, pld_b);
        rchk(`DPMX_OFS_D_PIN, 8'h05);
        chk("pld d", 3'h5, pld_d);
        u_dsp.extra = 3;
        u_dsp.wr(`DPMX_OFS_B_OD, 8'hFF);
        u_dsp.extra = 0;
        u_dsp.wr(`DPMX_OFS_C_DATA, 8'h0F);
        u_dsp.wr(`DPMX_OFS_C_OD, 8'hFF);
        u_dsp.wr(`DPMX_OFS_C_DIR, 8'hFF);
        settle();
        rchk(`DPMX_OFS_B_OD, 8'h0F);
        chk("b od oe", 8'hFA, b_oe);
        chk("c od oe", 8'hF0, c_oe);
        rchk(`DPMX_OFS_C_PIN, 8'h0F);
        u_dsp.wr(`DPMX_OFS_B_DIR, 8'h00);
        ext_b <= 8'hC3;
        settle();
        rchk(`DPMX_OFS_B_PIN, 8'hC3);
        u_dsp.sel(1'b1);
        settle();
        chk("byte space", 1'b1, bss);
        u_dsp.sel(1'b0);
        settle();
        chk("byte space", 1'b0, bss);
        set_fn(dpmx_pkg::DPMX_FN_MCELL, dpmx_pkg::DPMX_FN_INPUT);
        mc_b <= 8'h96;
        ext_c <= 8'h84;
        alt <= '{jtag_en: 1'b0, xjtag_en: 1'b0, rdybsy_en: 1'b0, full_mem: 1'b1};
        do_reset();
        chk_rst();
        chk("macrocell", 16'h96FF, {b_o, b_oe});
        chk("input pins", 16'h0084, {c_oe, pld_c});
        chk("decode", {2'b11, bus.addr}, dec);
        set_fn(dpmx_pkg::DPMX_FN_IO, dpmx_pkg::DPMX_FN_IO);
        alt <= '{jtag_en: 1'b1, xjtag_en: 1'b1, rdybsy_en: 1'b0, full_mem: 1'b0};
        tdo <= 1'b1;
        isp_status_out <= 1'b1;
        busy <= 1'b1;
        do_reset();
        chk("jtag pins", 4'h3, {c_oe[1:0], c_oe[6], c_o[6]});
        chk("status pins", 4'hE, {c_oe[3], c_o[3], c_oe[4], c_o[4]});
        alt <= '{jtag_en: 1'b0, xjtag_en: 1'b1, rdybsy_en: 1'b1, full_mem: 1'b0};
        do_reset();
        chk("ready pin", 2'h2, {c_oe[3], c_o[3]});
        rchk(`DPMX_OFS_STATUS, 8'h00);
        busy <= 1'b0;
        settle();
        chk("ready pin", 2'h3, {c_oe[3], c_o[3]});
        rchk(`DPMX_OFS_STATUS, 8'h01);
        finish_test();
    end
endmodule
